// ### pfrc_pkg.sv
// Purpose: Shared constants and types for the paged free-running counter
// Assumes: 32-bit AXI4-Lite register bus, 16-bit byte address
// Notes: Byte address of each register is four times its index
package pfrc_pkg;

  // ==========================================================
  // Register map
  localparam int PFRC_AW = 16;
  localparam logic [15:0] PFRC_IDX_RESULT_HI = 16'h1808;
  localparam logic [15:0] PFRC_IDX_RESULT_LO = 16'h1809;
  localparam logic [15:0] PFRC_IDX_PAGE_CTRL = 16'h180B;
  localparam logic [15:0] PFRC_ADDR_RESULT_HI = 16'(PFRC_IDX_RESULT_HI * 16'h0004);
  localparam logic [15:0] PFRC_ADDR_RESULT_LO = 16'(PFRC_IDX_RESULT_LO * 16'h0004);
  localparam logic [15:0] PFRC_ADDR_PAGE_CTRL = 16'(PFRC_IDX_PAGE_CTRL * 16'h0004);

  // ==========================================================
  // Control register fields
  localparam int PFRC_BIT_CLEAR = 7;
  localparam int PFRC_BIT_RUN = 5;
  localparam int PFRC_BIT_PAGE = 0;

  // ==========================================================
  // Reset values and responses
  localparam logic [15:0] PFRC_COUNT_RST = 16'h0000;
  localparam logic [15:0] PFRC_COUNT_STEP = 16'h0001;
  localparam logic PFRC_RUN_RST = 1'b0;
  localparam logic PFRC_PAGE_RST = 1'b0;
  localparam logic [1:0] PFRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFRC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PFRC_WR_IDLE = 2'h0,
    PFRC_WR_ADDR = 2'h1,
    PFRC_WR_RESP = 2'h3,
    PFRC_WR_DATA = 2'h2
  } pfrc_wr_e;

  typedef enum logic [1:0] {
    PFRC_SEL_NONE = 2'h0,
    PFRC_SEL_HI = 2'h1,
    PFRC_SEL_LO = 2'h2,
    PFRC_SEL_CTRL = 2'h3
  } pfrc_sel_e;

  typedef struct packed {
    pfrc_wr_e wst;
    logic [PFRC_AW-1:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic run;
    logic page;
    logic osc_prev;
    logic [15:0] cnt;
  } pfrc_state_s;

endpackage : pfrc_pkg

// ### pfrc_counter.sv
// Overview of operation
// - Released counter increments and wraps in all modes
// - 16-bit count read as high then low byte
// - Writing one to clear bit zeroes count
// - Count advances on both oscillator edges
// - Run bit zero freezes, one resumes counting
// - Page zero shows shared system registers instead
// - Page one lets clear and run act
// - Oscillator clocks counting regardless of bus activity
// - Result bytes read-only, reset to zero
//
// Purpose: Paged 16-bit free-running counter behind an AXI4-Lite slave
// Assumes: Oscillator and bus inputs synchronous to core_clk_in
// Notes: Shared system register contents arrive on plain input ports
module pfrc_counter
  import pfrc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic low_freq_oscillator_in,
  input wire logic [7:0] shared_system_reg_a_in,
  input wire logic [7:0] shared_system_reg_b_in,
  input wire logic [PFRC_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [PFRC_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  // ==========================================================
  // Address decode
  function automatic pfrc_sel_e reg_sel(input logic [PFRC_AW-1:0] addr);
    pfrc_sel_e sel;
    if (addr == PFRC_ADDR_RESULT_HI)
      sel = PFRC_SEL_HI;
    else if (addr == PFRC_ADDR_RESULT_LO)
      sel = PFRC_SEL_LO;
    else if (addr == PFRC_ADDR_PAGE_CTRL)
      sel = PFRC_SEL_CTRL;
    else
      sel = PFRC_SEL_NONE;
    return sel;
  endfunction : reg_sel

  pfrc_state_s st_r;
  pfrc_state_s st_nxt;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic inc_hit;
  logic clr_hit;
  logic [PFRC_AW-1:0] f_addr;
  logic [7:0] f_data;
  logic f_strb;
  pfrc_sel_e f_sel;
  pfrc_sel_e r_sel;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    aw_take = s_axi_awvalid_in && st_r.awready;
    w_take = s_axi_wvalid_in && st_r.wready;
    ar_take = s_axi_arvalid_in && st_r.arready;
    wr_fire = 1'b0;
    clr_hit = 1'b0;
    f_addr = aw_take ? s_axi_awaddr_in : st_r.waddr;
    f_data = w_take ? s_axi_wdata_in[7:0] : st_r.wdata;
    f_strb = w_take ? s_axi_wstrb_in[0] : st_r.wstrb0;
    f_sel = reg_sel(f_addr);
    r_sel = reg_sel(s_axi_araddr_in);
    // Either oscillator edge is a count tick; bus traffic plays no part
    inc_hit = st_r.run && (low_freq_oscillator_in != st_r.osc_prev);
    st_nxt.osc_prev = low_freq_oscillator_in;

    // Write channel: address and data in either order
    if (aw_take)
    begin
      st_nxt.waddr = s_axi_awaddr_in;
      st_nxt.awready = 1'b0;
    end
    if (w_take)
    begin
      st_nxt.wdata = s_axi_wdata_in[7:0];
      st_nxt.wstrb0 = s_axi_wstrb_in[0];
      st_nxt.wready = 1'b0;
    end
    case (st_r.wst)
      PFRC_WR_IDLE:
      begin
        if (aw_take && w_take)
          wr_fire = 1'b1;
        else if (aw_take)
          st_nxt.wst = PFRC_WR_ADDR;
        else if (w_take)
          st_nxt.wst = PFRC_WR_DATA;
      end
      PFRC_WR_ADDR:
      begin
        if (w_take)
          wr_fire = 1'b1;
      end
      PFRC_WR_DATA:
      begin
        if (aw_take)
          wr_fire = 1'b1;
      end
      default:
      begin
        if (s_axi_bready_in)
        begin
          st_nxt.wst = PFRC_WR_IDLE;
          st_nxt.bvalid = 1'b0;
          st_nxt.awready = 1'b1;
          st_nxt.wready = 1'b1;
        end
      end
    endcase

    // Register write effects
    if (wr_fire)
    begin
      st_nxt.wst = PFRC_WR_RESP;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (f_sel == PFRC_SEL_NONE) ? PFRC_RESP_SLVERR : PFRC_RESP_OKAY;
      if (f_sel == PFRC_SEL_CTRL && f_strb)
      begin
        st_nxt.page = f_data[PFRC_BIT_PAGE];
        // Run and clear only reach the counter while the page is open
        if (st_r.page)
        begin
          st_nxt.run = f_data[PFRC_BIT_RUN];
          clr_hit = f_data[PFRC_BIT_CLEAR];
        end
      end
      // Writes to the result bytes or shared registers change nothing here
    end

    // Counter: clear beats a coincident tick
    if (clr_hit)
      st_nxt.cnt = PFRC_COUNT_RST;
    else if (inc_hit)
      st_nxt.cnt = st_r.cnt + PFRC_COUNT_STEP;

    // Read channel
    if (ar_take)
    begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = PFRC_RESP_OKAY;
      if (r_sel == PFRC_SEL_HI)
        st_nxt.rdata = st_r.page ? st_r.cnt[15:8] : shared_system_reg_a_in;
      else if (r_sel == PFRC_SEL_LO)
        st_nxt.rdata = st_r.page ? st_r.cnt[7:0] : shared_system_reg_b_in;
      else if (r_sel == PFRC_SEL_CTRL)
        st_nxt.rdata = {2'h0, st_r.run, 5'h00};
      else
      begin
        st_nxt.rdata = 8'h00;
        st_nxt.rresp = PFRC_RESP_SLVERR;
      end
    end
    else if (st_r.rvalid && s_axi_rready_in)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r.wst <= PFRC_WR_IDLE;
      st_r.waddr <= '0;
      st_r.wdata <= 8'h00;
      st_r.wstrb0 <= 1'b0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.bvalid <= 1'b0;
      st_r.bresp <= PFRC_RESP_OKAY;
      st_r.arready <= 1'b1;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.rresp <= PFRC_RESP_OKAY;
      st_r.run <= PFRC_RUN_RST;
      st_r.page <= PFRC_PAGE_RST;
      st_r.osc_prev <= 1'b0;
      st_r.cnt <= PFRC_COUNT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_out = st_r.awready;
  assign s_axi_wready_out = st_r.wready;
  assign s_axi_bvalid_out = st_r.bvalid;
  assign s_axi_bresp_out = st_r.bresp;
  assign s_axi_arready_out = st_r.arready;
  assign s_axi_rvalid_out = st_r.rvalid;
  assign s_axi_rresp_out = st_r.rresp;
  assign s_axi_rdata_out = {24'h000000, st_r.rdata};

  // ==========================================================
  // Checks
  count_wrap_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (inc_hit && !clr_hit && st_r.cnt == 16'hFFFF) |=> (st_r.cnt == 16'h0000))
    else $error("counter did not wrap to zero");

  both_edges_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.run && !clr_hit && $changed(low_freq_oscillator_in))
      |=> (st_r.cnt == $past(st_r.cnt) + 16'h0001))
    else $error("oscillator edge did not advance counter");

  result_high_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && st_r.page && s_axi_araddr_in == PFRC_ADDR_RESULT_HI)
      |=> (s_axi_rvalid_out && s_axi_rdata_out == {24'h000000, $past(st_r.cnt[15:8])}))
    else $error("high result byte mismatch");

  result_low_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && st_r.page && s_axi_araddr_in == PFRC_ADDR_RESULT_LO)
      |=> (s_axi_rvalid_out && s_axi_rdata_out == {24'h000000, $past(st_r.cnt[7:0])}))
    else $error("low result byte mismatch");

  clear_zero_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && f_strb && st_r.page && f_data[PFRC_BIT_CLEAR])
      |=> (st_r.cnt == 16'h0000))
    else $error("clear write did not zero counter");

  halt_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!st_r.run && !clr_hit) |=> $stable(st_r.cnt))
    else $error("halted counter moved");

  page_closed_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && !st_r.page) |=> (st_r.run == $past(st_r.run)))
    else $error("run bit changed with page closed");

  shared_read_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && !st_r.page && s_axi_araddr_in == PFRC_ADDR_RESULT_HI)
      |=> (s_axi_rdata_out == {24'h000000, $past(shared_system_reg_a_in)}))
    else $error("shared register not returned");

  run_write_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && f_strb && st_r.page)
      |=> (st_r.run == $past(f_data[PFRC_BIT_RUN])))
    else $error("run bit not taken with page open");

  result_ro_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && (f_sel == PFRC_SEL_HI || f_sel == PFRC_SEL_LO) && !inc_hit)
      |=> $stable(st_r.cnt) ##1 (s_axi_bresp_out == 2'h0 || !s_axi_bvalid_out))
    else $error("result write changed counter");

  reset_idle_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (!st_r.run && !st_r.page && st_r.cnt == 16'h0000))
    else $error("control not cleared by reset");

  // ==========================================================
  // Paging and map checks
  page_write_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && f_strb)
      |=> (st_r.page == $past(f_data[PFRC_BIT_PAGE])))
    else $error("page bit not taken");

  page_keep_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!(wr_fire && f_sel == PFRC_SEL_CTRL && f_strb))
      |=> $stable(st_r.page))
    else $error("page bit moved without write");

  run_held_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!wr_fire)
      |=> $stable(st_r.run))
    else $error("run bit moved without write");

  clear_noop_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && f_strb && st_r.page
      && !f_data[PFRC_BIT_CLEAR] && !inc_hit) |=> $stable(st_r.cnt))
    else $error("clear bit zero changed counter");

  clear_halt_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_CTRL && f_strb && st_r.page
      && f_data[PFRC_BIT_CLEAR] && !f_data[PFRC_BIT_RUN]) |=> (!st_r.run && st_r.cnt == 16'h0000))
    else $error("halted clear did not zero counter");

  no_tick_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (st_r.run && !clr_hit && $stable(low_freq_oscillator_in))
      |=> $stable(st_r.cnt))
    else $error("counter moved without oscillator edge");

  shared_low_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && !st_r.page && s_axi_araddr_in == PFRC_ADDR_RESULT_LO)
      |=> (s_axi_rdata_out == {24'h000000, $past(shared_system_reg_b_in)}))
    else $error("shared low register not returned");

  run_read_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && s_axi_araddr_in == PFRC_ADDR_PAGE_CTRL)
      |=> (s_axi_rdata_out == {24'h000000, 2'h0, $past(st_r.run), 5'h00}))
    else $error("control read mismatch");

  result_resp_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && (f_sel == PFRC_SEL_HI || f_sel == PFRC_SEL_LO))
      |=> (s_axi_bvalid_out && s_axi_bresp_out == PFRC_RESP_OKAY))
    else $error("result write not answered okay");

  unmapped_write_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_fire && f_sel == PFRC_SEL_NONE)
      |=> (s_axi_bvalid_out && s_axi_bresp_out == PFRC_RESP_SLVERR))
    else $error("unmapped write not refused");

  unmapped_read_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (ar_take && r_sel == PFRC_SEL_NONE)
      |=> (s_axi_rresp_out == PFRC_RESP_SLVERR && s_axi_rdata_out == 32'h00000000))
    else $error("unmapped read not refused");

endmodule : pfrc_counter

// ### tb_pfrc_counter.sv
// Purpose: Self-checking bench for the paged free-running counter
// Assumes: Count ticks on every oscillator change while run is set
// Notes: Oscillator toggled by the bench, one change per tick
module tb_pfrc_counter
  import pfrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic osc = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rd_v;
  logic [1:0] rs;
  logic [15:0] c;
  int fails = 0, checked = 0, cycles = 0;
  always #10 core_clk_in = ~core_clk_in;
  pfrc_counter pfrc_counter_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .low_freq_oscillator_in(osc), .shared_system_reg_a_in(8'h5A),
    .shared_system_reg_b_in(8'hC3), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  // ==========================================================
  // Reporting
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask : chk_resp
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fails++;
      conclude();
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge core_clk_in);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        chk_resp(bresp, er);
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge core_clk_in);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic rd_cnt(output logic [15:0] v);
    rd(PFRC_ADDR_RESULT_HI, rd_v, rs);
    chk_resp(rs, PFRC_RESP_OKAY);
    v[15:8] = rd_v[7:0];
    rd(PFRC_ADDR_RESULT_LO, rd_v, rs);
    chk_resp(rs, PFRC_RESP_OKAY);
    v[7:0] = rd_v[7:0];
  endtask : rd_cnt
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      osc <= ~osc;
    end
    repeat (3) @(posedge core_clk_in);
  endtask : tick
  // ==========================================================
  // Tests
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(PFRC_ADDR_PAGE_CTRL, rd_v, rs);
    chk_data(rd_v, 32'h0000_0000);
    rd(PFRC_ADDR_RESULT_HI, rd_v, rs);
    chk_data(rd_v, 32'h0000_005A);
    rd(PFRC_ADDR_RESULT_LO, rd_v, rs);
    chk_data(rd_v, 32'h0000_00C3);
    tick(4);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h01, PFRC_RESP_OKAY);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0000);
    $display("test reset_defaults done");
    wr(PFRC_ADDR_RESULT_HI, 8'hFF, PFRC_RESP_OKAY);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h21, PFRC_RESP_OKAY);
    tick(5);
    rd(PFRC_ADDR_PAGE_CTRL, rd_v, rs);
    chk_data(rd_v, 32'h0000_0020);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0005);
    $display("test run_and_count done");
    wr(PFRC_ADDR_PAGE_CTRL, 8'h01, PFRC_RESP_OKAY);
    tick(3);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0005);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h81, PFRC_RESP_OKAY);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0000);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h21, PFRC_RESP_OKAY);
    tick(2);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h21, PFRC_RESP_OKAY);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0002);
    $display("test halt_and_clear done");
    wr(PFRC_ADDR_PAGE_CTRL, 8'h20, PFRC_RESP_OKAY);
    tick(6);
    rd(PFRC_ADDR_RESULT_HI, rd_v, rs);
    chk_data(rd_v, 32'h0000_005A);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h01, PFRC_RESP_OKAY);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0008);
    $display("test page_off_keeps_running done");
    tick(65536 - 5);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0003);
    rd(16'h0000, rd_v, rs);
    chk_resp(rs, PFRC_RESP_SLVERR);
    chk_data(rd_v, 32'h0000_0000);
    wr(16'h0000, 8'h00, PFRC_RESP_SLVERR);
    $display("test wrap_and_unmapped done");
    rst_n_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(PFRC_ADDR_PAGE_CTRL, rd_v, rs);
    chk_data(rd_v, 32'h0000_0000);
    rd(PFRC_ADDR_RESULT_LO, rd_v, rs);
    chk_data(rd_v, 32'h0000_00C3);
    tick(2);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h01, PFRC_RESP_OKAY);
    rd_cnt(c);
    chk_data({16'h0000, c}, 32'h0000_0000);
    wr(PFRC_ADDR_PAGE_CTRL, 8'h00, PFRC_RESP_OKAY);
    rd(PFRC_ADDR_RESULT_HI, rd_v, rs);
    chk_data(rd_v, 32'h0000_005A);
    $display("test mid_run_reset done");
    conclude();
  end
endmodule : tb_pfrc_counter
